// [rtl/acd_top.v]
// Purpose: aligned clock divider with matched delay and reset/release control
// Assumes: all input clocks and release arrive as pins well below clk/2, sampled by clk
// Notes: outputs are clk-domain registers; matched delay is two sync stages plus one register
// Function
// - make delayed primary, half, quarter and eighth rate outputs from primary input
// - divided outputs rise together with the delayed primary output, not input
// - delayed output keeps input duty; divided outputs are always 50/50
// - three aux clocks get the same delay as the primary clock
// - each delayed output keeps the duty cycle of its own input
// - divider reset forces every clock output low at once
// - delayed outputs start one cycle after registered reset release
// - without release gating, divided outputs start likewise after registered release
// - with gating, divided outputs wait for release rise, start at next primary rise
// - reset release synchronised to selected input clock, primary by default
// - release only gates the divided outputs, never the delayed ones
// - release gating is a boolean setting, default off; off means release ignored
// - release is ignored while divider reset is high
// - release acts on rising edge once; ignored afterwards until next reset
// - selection accepts exactly one of the four input clocks, primary default
//
// Our own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
`include "acd_map.vh"

module acd_top (
   input wire clk,
   input wire rst_n,
   input wire ce,
   // ahb-lite slave
   input wire hsel,
   input wire [11:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   // clock pins
   input wire primary_clk_in,
   input wire aux_clk_in_1,
   input wire aux_clk_in_2,
   input wire aux_clk_in_3,
   input wire release_in,
   // clock outputs
   output wire primary_delayed_out,
   output wire primary_half_out,
   output wire primary_quarter_out,
   output wire primary_eighth_out,
   output wire aux_delayed_out_1,
   output wire aux_delayed_out_2,
   output wire aux_delayed_out_3
);

   // control state
   reg divider_reset;
   reg release_gating_en;
   reg [1:0] reset_release_clock_select;

   // bus data phase
   reg dphase_write;
   reg [11:0] dphase_addr;

   // pin synchronisers
   reg [`ACD_NPIN-1:0] pin_meta;
   reg [`ACD_NPIN-1:0] pin_sync;
   reg [`ACD_NPIN-1:0] pin_prev;

   // release and run state
   reg release_armed;
   reg delayed_en;
   reg [3:0] out_gate;
   reg release_fired;
   reg div_run;
   reg [2:0] div_cnt;

   // output flops
   reg [3:0] delayed_q;
   reg half_q;
   reg quarter_q;
   reg eighth_q;

   wire addr_phase;
   wire primary_rise;
   wire sel_rise;
   wire release_rise;
   wire div_go;
   wire release_pending;

   // next values of the clocked state
   reg [3:0] next_out_gate;
   reg [3:0] next_delayed_q;
   reg next_release_fired;
   reg next_div_run;
   reg [2:0] next_div_cnt;
   reg next_half;
   reg next_quarter;
   reg next_eighth;

   // one-cycle pulse on a synced low-to-high step
   function rise_of;
      input now_level;
      input last_level;
      begin
         rise_of = now_level & ~last_level;
      end
   endfunction

   // divider reset wins over any stored level, with no clock edge needed
   function gate_out;
      input level;
      input force_low;
      begin
         gate_out = level & ~force_low;
      end
   endfunction

   function [31:0] read_word;
      input [11:0] addr;
      begin
         read_word = 32'h0000_0000;
         case (addr)
            `ACD_CTRL_OFS: begin
               read_word[`ACD_CTRL_DIVRST_BIT] = divider_reset;
               read_word[`ACD_CTRL_RELEN_BIT] = release_gating_en;
               read_word[`ACD_CTRL_SEL_MSB:`ACD_CTRL_SEL_LSB] = reset_release_clock_select;
            end
            `ACD_STAT_OFS: begin
               read_word[`ACD_STAT_DLYEN_BIT] = delayed_en;
               read_word[`ACD_STAT_DIVRUN_BIT] = div_run;
               read_word[`ACD_STAT_RELPEND_BIT] = release_pending;
               read_word[`ACD_STAT_RELFIRED_BIT] = release_fired;
               read_word[`ACD_STAT_CNT_MSB:`ACD_STAT_CNT_LSB] = div_cnt;
            end
            default: begin
               read_word = 32'h0000_0000;
            end
         endcase
      end
   endfunction

   // bus stalls while the clock enable is low so no access is lost
   assign hreadyout = ce;
   assign hresp = 1'b0;
   assign addr_phase = hsel & htrans[1] & hready & ce;

   always @(posedge clk) begin
      if (!rst_n) begin
         dphase_write <= 1'b0;
         dphase_addr <= 12'h000;
         hrdata <= 32'h0000_0000;
      end else if (ce) begin
         dphase_write <= addr_phase & hwrite;
         if (addr_phase) begin
            dphase_addr <= {haddr[11:2], 2'b00};
            hrdata <= hwrite ? 32'h0000_0000 : read_word({haddr[11:2], 2'b00});
         end
      end
   end

   // control register; unmapped writes are dropped
   always @(posedge clk) begin
      if (!rst_n) begin
         divider_reset <= `ACD_DIVRST_RESET;
         release_gating_en <= `ACD_RELEN_RESET;
         reset_release_clock_select <= `ACD_SEL_RESET;
      end else if (ce && dphase_write && dphase_addr == `ACD_CTRL_OFS) begin
         divider_reset <= hwdata[`ACD_CTRL_DIVRST_BIT];
         release_gating_en <= hwdata[`ACD_CTRL_RELEN_BIT];
         reset_release_clock_select <= hwdata[`ACD_CTRL_SEL_MSB:`ACD_CTRL_SEL_LSB];
      end
   end

   // pins pass two flops; only pin_sync and later are read
   always @(posedge clk) begin
      if (!rst_n) begin
         pin_meta <= 5'h00;
         pin_sync <= 5'h00;
         pin_prev <= 5'h00;
      end else if (ce) begin
         pin_meta <= {release_in, aux_clk_in_3, aux_clk_in_2, aux_clk_in_1, primary_clk_in};
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   assign primary_rise = rise_of(pin_sync[0], pin_prev[0]);
   assign sel_rise = rise_of(pin_sync[reset_release_clock_select],
                             pin_prev[reset_release_clock_select]);
   assign release_rise = rise_of(pin_sync[`ACD_REL_PIN], pin_prev[`ACD_REL_PIN]);

   // release is caught on the selected clock, outputs open one of its cycles later
   always @(posedge clk) begin
      if (!rst_n || divider_reset) begin
         release_armed <= 1'b0;
         delayed_en <= 1'b0;
      end else if (ce && sel_rise) begin
         release_armed <= 1'b1;
         delayed_en <= release_armed;
      end
   end

   // each gate opens only while its input is low, so no runt first pulse
   always @* begin
      next_out_gate = out_gate;
      if (!delayed_en) begin
         next_out_gate = 4'h0;
      end else if (ce) begin
         next_out_gate = out_gate | ~pin_sync[3:0];
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         out_gate <= 4'h0;
      end else begin
         out_gate <= next_out_gate;
      end
   end

   // one register stage for all four clocks keeps their relative phase
   always @* begin
      next_delayed_q = delayed_q;
      if (ce) begin
         next_delayed_q = pin_sync[3:0] & out_gate;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         delayed_q <= 4'h0;
      end else begin
         delayed_q <= next_delayed_q;
      end
   end

   // release input: acted on once per reset, ignored while reset or gating off
   always @* begin
      next_release_fired = release_fired;
      if (ce && release_gating_en && release_rise) begin
         next_release_fired = 1'b1;
      end
   end

   always @(posedge clk) begin
      if (!rst_n || divider_reset) begin
         release_fired <= 1'b0;
      end else begin
         release_fired <= next_release_fired;
      end
   end

   // waiting for the primary gate too keeps the first divided rise on a delayed rise
   assign div_go = out_gate[0] & (release_gating_en ? release_fired : 1'b1);
   assign release_pending = release_gating_en & ~release_fired & ~divider_reset;

   // divided clocks only change on a delayed primary rise; low phase = high phase
   always @* begin
      next_div_run = div_run;
      next_div_cnt = div_cnt;
      next_half = half_q;
      next_quarter = quarter_q;
      next_eighth = eighth_q;
      if (!div_go) begin
         next_div_run = 1'b0;
         next_div_cnt = 3'h0;
         next_half = 1'b0;
         next_quarter = 1'b0;
         next_eighth = 1'b0;
      end else if (ce && primary_rise) begin
         next_div_run = 1'b1;
         next_div_cnt = div_cnt + 3'h1;
         next_half = ~div_cnt[0];
         next_quarter = ~div_cnt[1];
         next_eighth = ~div_cnt[2];
      end
   end

   always @(posedge clk) begin
      if (!rst_n || divider_reset) begin
         div_run <= 1'b0;
         div_cnt <= 3'h0;
         half_q <= 1'b0;
         quarter_q <= 1'b0;
         eighth_q <= 1'b0;
      end else begin
         div_run <= next_div_run;
         div_cnt <= next_div_cnt;
         half_q <= next_half;
         quarter_q <= next_quarter;
         eighth_q <= next_eighth;
      end
   end

   // divider reset gates outputs without waiting for a clock edge
   assign primary_delayed_out = gate_out(delayed_q[0], divider_reset);
   assign aux_delayed_out_1 = gate_out(delayed_q[1], divider_reset);
   assign aux_delayed_out_2 = gate_out(delayed_q[2], divider_reset);
   assign aux_delayed_out_3 = gate_out(delayed_q[3], divider_reset);
   assign primary_half_out = gate_out(half_q, divider_reset);
   assign primary_quarter_out = gate_out(quarter_q, divider_reset);
   assign primary_eighth_out = gate_out(eighth_q, divider_reset);

endmodule // acd_top

// [shared/acd_map.vh]
// Purpose: register map, field positions and reset values of the aligned clock divider
// Assumes: AHB-Lite slave, 32-bit words, byte addresses
// Notes: definitions only
`ifndef ACD_MAP_VH
`define ACD_MAP_VH

// register byte offsets
`define ACD_CTRL_OFS 12'h000
`define ACD_STAT_OFS 12'h004

// control register fields
`define ACD_CTRL_DIVRST_BIT 0
`define ACD_CTRL_RELEN_BIT 1
`define ACD_CTRL_SEL_LSB 2
`define ACD_CTRL_SEL_MSB 3

// control register reset values
`define ACD_DIVRST_RESET 1'h1
`define ACD_RELEN_RESET 1'h0
`define ACD_SEL_RESET 2'h0

// reset release clock select encodings
`define ACD_SEL_PRIMARY 2'h0
`define ACD_SEL_AUX1 2'h1
`define ACD_SEL_AUX2 2'h2
`define ACD_SEL_AUX3 2'h3

// status register fields
`define ACD_STAT_DLYEN_BIT 0
`define ACD_STAT_DIVRUN_BIT 1
`define ACD_STAT_RELPEND_BIT 2
`define ACD_STAT_RELFIRED_BIT 3
`define ACD_STAT_CNT_LSB 4
`define ACD_STAT_CNT_MSB 6

// number of sampled input pins: four clocks and the release input
`define ACD_NPIN 5
`define ACD_REL_PIN 4

`endif

// [sim/acd_src.sv]
// Purpose: upstream clock source feeding the aligned clock divider
// Assumes: eight clk cycles per input clock period
// Notes: unequal duties and offsets so that duty or phase slips show
`timescale 1ns/10ps
module acd_src (
   input wire clk,
   input wire rel_go,
   output logic primary_clk_in = 1'b0,
   output logic aux_clk_in_1 = 1'b0,
   output logic aux_clk_in_2 = 1'b0,
   output logic aux_clk_in_3 = 1'b0,
   output logic release_in = 1'b0
);
   logic [2:0] ph = 3'h0;
   always @(posedge clk) begin
      ph <= ph + 3'h1;
      primary_clk_in <= ph < 3'h3;
      aux_clk_in_1 <= ph >= 3'h2 && ph < 3'h6;
      aux_clk_in_2 <= ph >= 3'h3;
      aux_clk_in_3 <= ph >= 3'h6;
      // lock indication only moves with a primary rise, so setup is met
      if (ph == 3'h0) release_in <= rel_go;
   end
endmodule // acd_src

// [sim/acd_top_assertions.sv]
// Purpose: port checks of the aligned clock divider
// Assumes: ce held high, input clocks far slower than clk
// Notes: matched delay is three clk edges for every clock
`timescale 1ns/10ps
module acd_chk (
   input logic clk,
   input logic rst_n,
   input logic ce,
   input logic hreadyout,
   input logic primary_clk_in,
   input logic aux_clk_in_1,
   input logic aux_clk_in_2,
   input logic aux_clk_in_3,
   input logic primary_delayed_out,
   input logic primary_half_out,
   input logic primary_quarter_out,
   input logic primary_eighth_out,
   input logic aux_delayed_out_1,
   input logic aux_delayed_out_2,
   input logic aux_delayed_out_3
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_ready_ce: assert property (hreadyout == ce) else $error("hreadyout differs from ce");
   a_dly_pri: assert property (primary_delayed_out |-> $past(primary_clk_in, 3))
      else $error("primary output high without input");
   a_dly_aux1: assert property (aux_delayed_out_1 |-> $past(aux_clk_in_1, 3))
      else $error("aux1 output high without input");
   a_dly_aux2: assert property (aux_delayed_out_2 |-> $past(aux_clk_in_2, 3))
      else $error("aux2 output high without input");
   a_dly_aux3: assert property (aux_delayed_out_3 |-> $past(aux_clk_in_3, 3))
      else $error("aux3 output high without input");
   a_half_align: assert property ($rose(primary_half_out) |-> $rose(primary_delayed_out))
      else $error("half rise off primary rise");
   a_quarter_align: assert property ($rose(primary_quarter_out) |-> $rose(primary_half_out))
      else $error("quarter rise off half rise");
   a_eighth_align: assert property ($rose(primary_eighth_out) |-> $rose(primary_quarter_out))
      else $error("eighth rise off quarter rise");
   a_half_step: assert property ($changed(primary_half_out) |->
      $rose(primary_delayed_out) || !primary_delayed_out) else $error("half moved off step");
endmodule // acd_chk
bind acd_top acd_chk u_chk (.*);

// [sim/aligned_clock_divider_tb.sv]
// Purpose: self-checking bench of the aligned clock divider
// Assumes: ce dropped only once, under divider reset, to see the bus stall
// Notes: output duty measured as high counts over 64 cycles
`timescale 1ns/10ps
module aligned_clock_divider_tb;
   logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0, rel_go = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [11:0] haddr = 12'h000;
   logic [31:0] hwdata = 32'h0000_0000, q, d;
   int n_mismatch = 0, tests_run = 0, seed = 32'h1cae_70bc;
   wire hready, hreadyout, hresp, primary_clk_in, aux_clk_in_1, aux_clk_in_2, aux_clk_in_3;
   wire release_in, primary_delayed_out, primary_half_out, primary_quarter_out;
   wire primary_eighth_out, aux_delayed_out_1, aux_delayed_out_2, aux_delayed_out_3;
   wire [31:0] hrdata;
   wire [6:0] o = {aux_delayed_out_3, aux_delayed_out_2, aux_delayed_out_1, primary_eighth_out,
      primary_quarter_out, primary_half_out, primary_delayed_out};
   assign hready = hreadyout;
   acd_top dut (.*);
   acd_src src (.*);
   initial forever #50 clk = ~clk;
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
   end
   task end_of_test;
      if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      q = hrdata;
   endtask
   // model: high counts follow from the source duties, divided ones are half
   task automatic win(input int r, input int dv);
      int c[7];
      int e[7];
      e = '{24 * r, 32 * dv, 32 * dv, 32 * dv, 32 * r, 40 * r, 16 * r};
      repeat (64) begin
         @(negedge clk);
         for (int i = 0; i < 7; i++) c[i] += o[i];
      end
      for (int i = 0; i < 7; i++) chk("high count", c[i], e[i]);
   endtask
   initial begin
      #500000;
      n_mismatch++;
      end_of_test;
   end
   initial begin
      @(posedge rst_n);
      bus(1'b0, 12'h000, 32'h0000_0000);
      chk("ctrl reset", q, 32'h0000_0001);
      chk("okay response", hresp, 32'h0000_0000);
      win(0, 0);
      for (int s = 0; s < 4; s++) begin
         bus(1'b1, 12'h000, 32'(s) << 2);
         repeat (40) @(posedge clk);
         win(1, 1);
         bus(1'b1, 12'h000, (32'(s) << 2) | 32'h0000_0001);
         #1 chk("outputs in reset", o, 32'h0000_0000);
      end
      ce <= 1'b0;
      @(posedge clk);
      #1 chk("stall ready", hreadyout, 32'h0000_0000);
      @(posedge clk);
      ce <= 1'b1;
      d = $random(seed) & 32'h0000_000c;
      bus(1'b1, 12'h000, d | 32'h0000_0001);
      bus(1'b1, 12'h010, $random(seed));
      bus(1'b0, 12'h010, 32'h0000_0000);
      chk("unmapped read", q, 32'h0000_0000);
      bus(1'b0, 12'h000, 32'h0000_0000);
      chk("ctrl readback", q, d | 32'h0000_0001);
      // gating on while lock rises under reset: that edge must not count
      bus(1'b1, 12'h000, 32'h0000_0003);
      rel_go <= 1'b1;
      repeat (40) @(posedge clk);
      bus(1'b1, 12'h000, 32'h0000_0002);
      repeat (40) @(posedge clk);
      win(1, 0);
      rel_go <= 1'b0;
      repeat (20) @(posedge clk);
      rel_go <= 1'b1;
      repeat (40) @(posedge clk);
      win(1, 1);
      bus(1'b0, 12'h004, 32'h0000_0000);
      chk("status", q & 32'h0000_000f, 32'h0000_000b);
      end_of_test;
   end
endmodule // aligned_clock_divider_tb
